// File: common/glr_pkg.sv
// glr_pkg: shared constants and types for the load model and relaxation block
// assumes a 50 MHz system clock and plain-port configuration inputs
package glr_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int SEC_PERIOD_S = 1;
    localparam int SEC_CYCLES = CLK_HZ * SEC_PERIOD_S;
    localparam int OCV_WAIT_MIN = 30;
    localparam int OCV_WAIT_S = OCV_WAIT_MIN * 60;
    localparam int FILT_TAU_S = 14;
    localparam logic [15:0] SLOPE_LIMIT_UV = 16'h0004;
    localparam logic [15:0] C_DIV = 16'h0005;
    localparam logic [2:0] SRC_MAX = 3'h6;
    localparam logic [2:0] SRC_DEF_CC = 3'h1;
    localparam logic [2:0] SRC_DEF_CP = 3'h0;
    localparam logic MODEL_CC = 1'b0;
    localparam logic MODEL_CP = 1'b1;
    localparam int CTR_W = 13;
    typedef enum logic [1:0] {
        GLR_FLOW = 2'b00,
        GLR_RELAX = 2'b01,
        GLR_OCV = 2'b11
    } glr_state_e;
endpackage

// File: common/glr_tick_if.sv
// glr_tick_if: one-second tick between the divider and the core
// assumes a single clock domain
`timescale 1ns/1ps
`default_nettype none
interface glr_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface
`default_nettype wire

// File: verif/glr_host_model.sv
// glr_host_model: host side settings for current thresholds
// assumes the bench reads the gauge results straight from the core ports
`timescale 1ns/1ps
`default_nettype none
module glr_host_model #(
    parameter logic [15:0] DSG_MA = 16'h003C,
    parameter logic [15:0] CHG_MA = 16'h004B,
    parameter logic [15:0] STANDBY_MA = 16'h0014
) (
    output logic [15:0] dsg_detect_ma,
    output logic [15:0] chg_detect_ma,
    output logic [15:0] relax_entry_ma
);
    assign dsg_detect_ma = DSG_MA;
    assign chg_detect_ma = CHG_MA;
    // entry level kept above standby current
    assign relax_entry_ma = STANDBY_MA + 16'h0014;
endmodule
`default_nettype wire

// File: verif/test_gauge_load_model_relaxation.sv
// test_gauge_load_model_relaxation: directed bench for glr_core
// assumes thresholds 60/75 mA and entry level 40 mA from the host model
`timescale 1ns/1ps
`default_nettype none
module test_gauge_load_model_relaxation;
    logic CLK, RST_N, LOAD_MODEL, MEAS_VALID, RESERVE_COMP_EN, QMAX_MEASURED_VALID;
    logic [2:0] RATE_SRC;
    logic signed [15:0] MEAN_CURRENT, PREV_AVG_CURRENT, PRES_AVG_CURRENT, PREV_AVG_POWER;
    logic signed [15:0] PRES_AVG_POWER, HYPOTHETICAL_RATE, USER_RATE;
    logic [15:0] VOLTAGE_MV, SLOPE_UV_S, NOMINAL_CHARGE, NOMINAL_ENERGY, QMAX_INIT;
    logic [15:0] REMAINING_CHARGE, REMAINING_ENERGY, RESERVE_CHARGE, RESERVE_ENERGY, QMAX_MEASURED;
    logic [12:0] DSG_SETTLE_S;
    logic [7:0] CHG_SETTLE_S;
    logic [5:0] RELAX_EXIT_S;
    wire logic [15:0] DSG_DETECT_MA, CHG_DETECT_MA, RELAX_ENTRY_MA;
    logic LOAD_MODEL_STATUS_BIT, LOAD_RATE_IS_POWER, RESERVE_NOLOAD, DISCHARGING, CHARGING;
    logic RELAXED, OCV_ALLOWED, QMAX_LEARN_EN;
    logic signed [31:0] LOAD_RATE;
    logic [16:0] TOTAL_CHARGE, TOTAL_ENERGY;
    logic [15:0] QMAX;
    int fails = 0;
    int checks_done = 0;
    glr_host_model i_glr_host_model (.dsg_detect_ma(DSG_DETECT_MA),
        .chg_detect_ma(CHG_DETECT_MA), .relax_entry_ma(RELAX_ENTRY_MA));
    glr_core #(.TICK_CYCLES(4)) i_glr_core (.CLK(CLK), .RST_N(RST_N), .LOAD_MODEL(LOAD_MODEL),
        .RATE_SRC(RATE_SRC),
        .MEAS_VALID(MEAS_VALID), .MEAN_CURRENT(MEAN_CURRENT), .VOLTAGE_MV(VOLTAGE_MV),
        .SLOPE_UV_S(SLOPE_UV_S), .PREV_AVG_CURRENT(PREV_AVG_CURRENT),
        .PRES_AVG_CURRENT(PRES_AVG_CURRENT), .PREV_AVG_POWER(PREV_AVG_POWER),
        .PRES_AVG_POWER(PRES_AVG_POWER), .NOMINAL_CHARGE(NOMINAL_CHARGE),
        .NOMINAL_ENERGY(NOMINAL_ENERGY), .HYPOTHETICAL_RATE(HYPOTHETICAL_RATE),
        .USER_RATE(USER_RATE), .REMAINING_CHARGE(REMAINING_CHARGE),
        .REMAINING_ENERGY(REMAINING_ENERGY), .RESERVE_CHARGE(RESERVE_CHARGE),
        .RESERVE_ENERGY(RESERVE_ENERGY), .RESERVE_COMP_EN(RESERVE_COMP_EN),
        .DSG_DETECT_MA(DSG_DETECT_MA), .CHG_DETECT_MA(CHG_DETECT_MA),
        .RELAX_ENTRY_MA(RELAX_ENTRY_MA), .DSG_SETTLE_S(DSG_SETTLE_S),
        .CHG_SETTLE_S(CHG_SETTLE_S), .RELAX_EXIT_S(RELAX_EXIT_S), .QMAX_INIT(QMAX_INIT),
        .QMAX_MEASURED(QMAX_MEASURED), .QMAX_MEASURED_VALID(QMAX_MEASURED_VALID),
        .LOAD_MODEL_STATUS_BIT(LOAD_MODEL_STATUS_BIT), .LOAD_RATE(LOAD_RATE),
        .LOAD_RATE_IS_POWER(LOAD_RATE_IS_POWER), .TOTAL_CHARGE(TOTAL_CHARGE),
        .TOTAL_ENERGY(TOTAL_ENERGY), .RESERVE_NOLOAD(RESERVE_NOLOAD),
        .DISCHARGING(DISCHARGING), .CHARGING(CHARGING), .RELAXED(RELAXED),
        .OCV_ALLOWED(OCV_ALLOWED), .QMAX_LEARN_EN(QMAX_LEARN_EN), .QMAX(QMAX));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    task automatic step(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t value got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_relax(input logic exp, input int n);
        int i;
        for (i = 0; i < n && RELAXED !== exp; i++) step(1);
        chk_bit(RELAXED, exp);
    endtask
    task automatic complete_run;
        $display("checks_done %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    function automatic logic signed [31:0] exp_rate(input logic m, input logic [2:0] c,
            input logic signed [15:0] f);
        logic [2:0] k;
        k = (c > glr_pkg::SRC_MAX) ? (m ? glr_pkg::SRC_DEF_CP : glr_pkg::SRC_DEF_CC) : c;
        case (k)
            3'h0: return m ? 32'(PREV_AVG_POWER) : 32'(PREV_AVG_CURRENT);
            3'h1: return m ? 32'(PRES_AVG_POWER) : 32'(PRES_AVG_CURRENT);
            3'h2: return m ? 32'(int'(MEAN_CURRENT) * int'(VOLTAGE_MV)) : 32'(MEAN_CURRENT);
            3'h3: return m ? 32'(int'(f) * int'(VOLTAGE_MV)) : 32'(f);
            3'h4: return m ? 32'(NOMINAL_ENERGY / glr_pkg::C_DIV)
                : 32'(NOMINAL_CHARGE / glr_pkg::C_DIV);
            3'h5: return m ? 32'(HYPOTHETICAL_RATE) * 10 : 32'(HYPOTHETICAL_RATE);
            default: return m ? 32'(USER_RATE) * 10 : 32'(USER_RATE);
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        complete_run;
    end
    initial begin
        RST_N = 1'b0; LOAD_MODEL = 1'b0; RATE_SRC = 3'h3; MEAS_VALID = 1'b0;
        MEAN_CURRENT = 16'h0578; VOLTAGE_MV = 16'h0E10; SLOPE_UV_S = 16'h0010;
        PREV_AVG_CURRENT = 16'hFED4; PRES_AVG_CURRENT = 16'hFF38; PREV_AVG_POWER = 16'hFC00;
        PRES_AVG_POWER = 16'hFE00; NOMINAL_CHARGE = 16'h05DC; NOMINAL_ENERGY = 16'h1644;
        HYPOTHETICAL_RATE = 16'hFF9C; USER_RATE = 16'h0032; REMAINING_CHARGE = 16'hFFFF;
        REMAINING_ENERGY = 16'h0100; RESERVE_CHARGE = 16'h0002; RESERVE_ENERGY = 16'h0030;
        RESERVE_COMP_EN = 1'b0; DSG_SETTLE_S = 13'h0005; CHG_SETTLE_S = 8'h05;
        RELAX_EXIT_S = 6'h0A; QMAX_INIT = 16'h05DC; QMAX_MEASURED = 16'h0000;
        QMAX_MEASURED_VALID = 1'b0;
        step(8);
        RST_N = 1'b1;
        step(2);
        chk_val(32'(QMAX), 32'h0000_05DC);
        // filter steps: 0 -> 100 -> 192
        MEAS_VALID = 1'b1; step(1); MEAS_VALID = 1'b0; step(2);
        chk_val(LOAD_RATE, 32'h0000_0064);
        MEAS_VALID = 1'b1; step(1); MEAS_VALID = 1'b0; step(2);
        chk_val(LOAD_RATE, 32'h0000_00C0);
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 8; c++) begin
                LOAD_MODEL = 1'(m); RATE_SRC = 3'(c); step(2);
                chk_val(LOAD_RATE, exp_rate(1'(m), 3'(c), 16'h00C0));
                chk_bit(LOAD_RATE_IS_POWER, 1'(m));
                chk_bit(LOAD_MODEL_STATUS_BIT, 1'(m));
            end
        end
        for (int e = 0; e < 2; e++) begin
            RESERVE_COMP_EN = 1'(e); step(2);
            chk_bit(RESERVE_NOLOAD, 1'(e));
            chk_val(32'(TOTAL_CHARGE), 32'h0001_0001);
            chk_val(32'(TOTAL_ENERGY), 32'h0000_0130);
        end
        MEAN_CURRENT = 16'hFFC3; step(2); chk_bit(DISCHARGING, 1'b1);
        MEAN_CURRENT = 16'hFFC4; step(2); chk_bit(DISCHARGING, 1'b0);
        MEAN_CURRENT = 16'h004C; step(2); chk_bit(CHARGING, 1'b1);
        MEAN_CURRENT = 16'h004B; step(2); chk_bit(CHARGING, 1'b0);
        // load held well below a C/20 rate while relaxing
        DSG_SETTLE_S = 13'h0000; MEAN_CURRENT = 16'h000A;
        wait_relax(1'b1, 4);
        chk_bit(OCV_ALLOWED, 1'b0);
        SLOPE_UV_S = 16'h0003; #1 chk_bit(QMAX_LEARN_EN, 1'b0);
        step(7000); chk_bit(OCV_ALLOWED, 1'b0);
        for (int i = 0; i < 400 && OCV_ALLOWED !== 1'b1; i++) step(1);
        chk_bit(OCV_ALLOWED, 1'b1);
        chk_bit(QMAX_LEARN_EN, 1'b1);
        QMAX_MEASURED = 16'h0578; QMAX_MEASURED_VALID = 1'b1; step(1);
        QMAX_MEASURED_VALID = 1'b0; step(1); chk_val(32'(QMAX), 32'h0000_0578);
        SLOPE_UV_S = 16'h0004; #1 chk_bit(QMAX_LEARN_EN, 1'b0);
        QMAX_MEASURED = 16'h0111; QMAX_MEASURED_VALID = 1'b1; step(1);
        QMAX_MEASURED_VALID = 1'b0; step(1); chk_val(32'(QMAX), 32'h0000_0578);
        MEAN_CURRENT = 16'h0064; step(30); chk_bit(RELAXED, 1'b1);
        wait_relax(1'b0, 20);
        DSG_SETTLE_S = 13'h0005; CHG_SETTLE_S = 8'h00; MEAN_CURRENT = 16'hFFF6;
        wait_relax(1'b1, 4);
        MEAN_CURRENT = 16'hFF00; wait_relax(1'b0, 50);
        DSG_SETTLE_S = 13'h0010; CHG_SETTLE_S = 8'h14; MEAN_CURRENT = 16'h0005; step(40);
        chk_bit(RELAXED, 1'b0);
        MEAN_CURRENT = 16'h0064; step(1); MEAN_CURRENT = 16'h0005; step(40);
        chk_bit(RELAXED, 1'b0);
        wait_relax(1'b1, 40);
        complete_run;
    end
endmodule
`default_nettype wire

// File: verilog/glr_core.sv
// glr_core: load model rate selection, reserve handling, current direction and relaxation
// assumes measurements arrive once per second, synchronous to CLK, signed mA, unsigned mV and uV/s
`timescale 1ns/1ps
`default_nettype none
module glr_core #(
    parameter int TICK_CYCLES = glr_pkg::SEC_CYCLES
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic LOAD_MODEL,
    input wire logic [2:0] RATE_SRC,
    input wire logic MEAS_VALID,
    input wire logic signed [15:0] MEAN_CURRENT,
    input wire logic [15:0] VOLTAGE_MV,
    input wire logic [15:0] SLOPE_UV_S,
    input wire logic signed [15:0] PREV_AVG_CURRENT,
    input wire logic signed [15:0] PRES_AVG_CURRENT,
    input wire logic signed [15:0] PREV_AVG_POWER,
    input wire logic signed [15:0] PRES_AVG_POWER,
    input wire logic [15:0] NOMINAL_CHARGE,
    input wire logic [15:0] NOMINAL_ENERGY,
    input wire logic signed [15:0] HYPOTHETICAL_RATE,
    input wire logic signed [15:0] USER_RATE,
    input wire logic [15:0] REMAINING_CHARGE,
    input wire logic [15:0] REMAINING_ENERGY,
    input wire logic [15:0] RESERVE_CHARGE,
    input wire logic [15:0] RESERVE_ENERGY,
    input wire logic RESERVE_COMP_EN,
    input wire logic [15:0] DSG_DETECT_MA,
    input wire logic [15:0] CHG_DETECT_MA,
    input wire logic [15:0] RELAX_ENTRY_MA,
    input wire logic [12:0] DSG_SETTLE_S,
    input wire logic [7:0] CHG_SETTLE_S,
    input wire logic [5:0] RELAX_EXIT_S,
    input wire logic [15:0] QMAX_INIT,
    input wire logic [15:0] QMAX_MEASURED,
    input wire logic QMAX_MEASURED_VALID,
    output logic LOAD_MODEL_STATUS_BIT,
    output logic signed [31:0] LOAD_RATE,
    output logic LOAD_RATE_IS_POWER,
    output logic [16:0] TOTAL_CHARGE,
    output logic [16:0] TOTAL_ENERGY,
    output logic RESERVE_NOLOAD,
    output logic DISCHARGING,
    output logic CHARGING,
    output logic RELAXED,
    output logic OCV_ALLOWED,
    output logic QMAX_LEARN_EN,
    output logic [15:0] QMAX
);
    glr_tick_if sec_if ();
    glr_sec_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk(CLK),
        .rst_n(RST_N),
        .t(sec_if)
    );
    logic tick;
    assign tick = sec_if.tick;

    ////////////////////////////////////////////////////////////////////////////
    // source selection
    function automatic logic [2:0] eff_src(input logic [2:0] src, input logic model);
        if (src > glr_pkg::SRC_MAX) begin
            return (model == glr_pkg::MODEL_CP) ? glr_pkg::SRC_DEF_CP : glr_pkg::SRC_DEF_CC;
        end
        return src;
    endfunction

    logic signed [31:0] filt_q;
    logic signed [31:0] rate_d;
    logic signed [31:0] filt_i;
    logic signed [31:0] mean_i;
    logic [2:0] src;
    assign filt_i = filt_q;
    assign mean_i = 32'(MEAN_CURRENT);
    assign src = eff_src(RATE_SRC, LOAD_MODEL);

    // first-order low-pass, step 1/tau per measurement
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            filt_q <= 32'h0000_0000;
        end else if (MEAS_VALID) begin
            filt_q <= filt_q + (mean_i - filt_q) / glr_pkg::FILT_TAU_S;
        end
    end

    always_comb begin
        rate_d = 32'h0000_0000;
        if (LOAD_MODEL == glr_pkg::MODEL_CC) begin
            unique case (src)
                3'h0: rate_d = 32'(PREV_AVG_CURRENT);
                3'h1: rate_d = 32'(PRES_AVG_CURRENT);
                3'h2: rate_d = mean_i;
                3'h3: rate_d = filt_i;
                3'h4: rate_d = 32'(NOMINAL_CHARGE / glr_pkg::C_DIV);
                3'h5: rate_d = 32'(HYPOTHETICAL_RATE);
                default: rate_d = 32'(USER_RATE);
            endcase
        end else begin
            unique case (src)
                3'h0: rate_d = 32'(PREV_AVG_POWER);
                3'h1: rate_d = 32'(PRES_AVG_POWER);
                3'h2: rate_d = mean_i * $signed({16'h0000, VOLTAGE_MV});
                3'h3: rate_d = filt_i * $signed({16'h0000, VOLTAGE_MV});
                3'h4: rate_d = 32'(NOMINAL_ENERGY / glr_pkg::C_DIV);
                3'h5: rate_d = 32'(HYPOTHETICAL_RATE) * 32'sd10;
                default: rate_d = 32'(USER_RATE) * 32'sd10;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            LOAD_RATE <= 32'h0000_0000;
            LOAD_RATE_IS_POWER <= 1'b0;
            LOAD_MODEL_STATUS_BIT <= 1'b0;
        end else begin
            LOAD_RATE <= rate_d;
            LOAD_RATE_IS_POWER <= LOAD_MODEL;
            LOAD_MODEL_STATUS_BIT <= LOAD_MODEL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reserve
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            TOTAL_CHARGE <= 17'h0_0000;
            TOTAL_ENERGY <= 17'h0_0000;
            RESERVE_NOLOAD <= 1'b0;
        end else begin
            TOTAL_CHARGE <= {1'b0, REMAINING_CHARGE} + {1'b0, RESERVE_CHARGE};
            TOTAL_ENERGY <= {1'b0, REMAINING_ENERGY} + {1'b0, RESERVE_ENERGY};
            RESERVE_NOLOAD <= RESERVE_COMP_EN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // direction
    logic [15:0] mag;
    assign mag = MEAN_CURRENT[15] ? 16'(-MEAN_CURRENT) : 16'(MEAN_CURRENT);
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            DISCHARGING <= 1'b0;
            CHARGING <= 1'b0;
        end else begin
            DISCHARGING <= MEAN_CURRENT[15] && (mag > DSG_DETECT_MA);
            CHARGING <= !MEAN_CURRENT[15] && (mag > CHG_DETECT_MA);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // relaxation
    glr_pkg::glr_state_e st_q;
    logic [glr_pkg::CTR_W-1:0] quiet_q;
    logic [glr_pkg::CTR_W-1:0] busy_q;
    logic [10:0] relax_s_q;
    logic quiet;
    assign quiet = mag < RELAX_ENTRY_MA;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            quiet_q <= 13'h0000;
            busy_q <= 13'h0000;
        end else begin
            if (!quiet) begin
                quiet_q <= 13'h0000;
            end else if (tick && quiet_q != 13'h1FFF) begin
                quiet_q <= quiet_q + 13'h0001;
            end
            if (quiet) begin
                busy_q <= 13'h0000;
            end else if (tick && busy_q != 13'h1FFF) begin
                busy_q <= busy_q + 13'h0001;
            end
        end
    end

    logic enter_ok;
    logic exit_ok;
    assign enter_ok = quiet && (quiet_q >= DSG_SETTLE_S || quiet_q >= {5'h00, CHG_SETTLE_S});
    assign exit_ok = !quiet && busy_q >= {7'h00, RELAX_EXIT_S};

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= glr_pkg::GLR_FLOW;
        end else begin
            unique case (st_q)
                glr_pkg::GLR_FLOW: begin
                    if (enter_ok) begin
                        st_q <= glr_pkg::GLR_RELAX;
                    end
                end
                glr_pkg::GLR_RELAX: begin
                    if (exit_ok) begin
                        st_q <= glr_pkg::GLR_FLOW;
                    end else if (relax_s_q >= 11'(glr_pkg::OCV_WAIT_S)) begin
                        st_q <= glr_pkg::GLR_OCV;
                    end
                end
                default: begin
                    if (exit_ok) begin
                        st_q <= glr_pkg::GLR_FLOW;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            relax_s_q <= 11'h000;
        end else if (st_q != glr_pkg::GLR_RELAX) begin
            relax_s_q <= 11'h000;
        end else if (tick) begin
            relax_s_q <= relax_s_q + 11'h001;
        end
    end

    assign RELAXED = (st_q != glr_pkg::GLR_FLOW);
    assign OCV_ALLOWED = (st_q == glr_pkg::GLR_OCV);
    assign QMAX_LEARN_EN = OCV_ALLOWED && (SLOPE_UV_S < glr_pkg::SLOPE_LIMIT_UV);

    ////////////////////////////////////////////////////////////////////////////
    // capacity
    logic qmax_init_done_q;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            QMAX <= 16'h0000;
            qmax_init_done_q <= 1'b0;
        end else if (!qmax_init_done_q) begin
            QMAX <= QMAX_INIT;
            qmax_init_done_q <= 1'b1;
        end else if (QMAX_MEASURED_VALID && QMAX_LEARN_EN) begin
            QMAX <= QMAX_MEASURED;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_status_mirror: assert property (@(posedge CLK) disable iff (!RST_N)
        $past(RST_N) |-> LOAD_MODEL_STATUS_BIT == $past(LOAD_MODEL))
        else $error("status bit mismatch");
    a_default_src: assert property (@(posedge CLK) disable iff (!RST_N)
        (RATE_SRC == 3'h7 && !LOAD_MODEL) |=> LOAD_RATE == $past(32'(PRES_AVG_CURRENT)))
        else $error("bad default source");
    a_cc_nominal: assert property (@(posedge CLK) disable iff (!RST_N)
        (RATE_SRC == 3'h4 && !LOAD_MODEL) |=> LOAD_RATE == 32'($past(NOMINAL_CHARGE) / 16'd5))
        else $error("bad c/5 rate");
    a_cp_hypo: assert property (@(posedge CLK) disable iff (!RST_N)
        (RATE_SRC == 3'h5 && LOAD_MODEL) |=> LOAD_RATE == $past(32'(HYPOTHETICAL_RATE)) * 10)
        else $error("bad power unit");
    a_reserve_sum: assert property (@(posedge CLK) disable iff (!RST_N)
        $past(RST_N) |->
        TOTAL_CHARGE == $past({1'b0, REMAINING_CHARGE}) + $past({1'b0, RESERVE_CHARGE}))
        else $error("bad reserve charge");
    a_reserve_energy: assert property (@(posedge CLK) disable iff (!RST_N)
        $past(RST_N) |->
        TOTAL_ENERGY == $past({1'b0, REMAINING_ENERGY}) + $past({1'b0, RESERVE_ENERGY}))
        else $error("bad reserve energy");
    a_dsg_flag: assert property (@(posedge CLK) disable iff (!RST_N)
        (MEAN_CURRENT[15] && mag > DSG_DETECT_MA) |=> DISCHARGING) else $error("no discharge");
    a_chg_flag: assert property (@(posedge CLK) disable iff (!RST_N)
        (!MEAN_CURRENT[15] && mag > CHG_DETECT_MA) |=> CHARGING) else $error("no charge");
    a_quiet_restart: assert property (@(posedge CLK) disable iff (!RST_N)
        !quiet |=> quiet_q == 13'h0000) else $error("timer not restarted");
    a_enter_relax: assert property (@(posedge CLK) disable iff (!RST_N)
        (!RELAXED && enter_ok) |=> RELAXED) else $error("missed relax entry");
    a_stay_relax: assert property (@(posedge CLK) disable iff (!RST_N)
        (RELAXED && !exit_ok) |=> RELAXED) else $error("early relax exit");
    a_learn_slope: assert property (@(posedge CLK) disable iff (!RST_N)
        $changed(QMAX) && $past(qmax_init_done_q) |->
        $past(SLOPE_UV_S) < 16'd4 && $past(OCV_ALLOWED))
        else $error("learn gate");
    a_ocv_wait: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(OCV_ALLOWED) |-> $past(relax_s_q) >= 11'd1800) else $error("ocv too early");
    c_relax: cover property (@(posedge CLK) disable iff (!RST_N) $rose(RELAXED));
    c_ocv: cover property (@(posedge CLK) disable iff (!RST_N) $rose(OCV_ALLOWED));
    c_learn: cover property (@(posedge CLK) disable iff (!RST_N)
        QMAX_MEASURED_VALID && QMAX_LEARN_EN);
    c_exit: cover property (@(posedge CLK) disable iff (!RST_N) $fell(RELAXED));
    c_cp_default: cover property (@(posedge CLK) disable iff (!RST_N)
        LOAD_MODEL && RATE_SRC == 3'h7);
endmodule
`default_nettype wire

// File: verilog/glr_sec_tick.sv
// glr_sec_tick: divides the system clock into a one-cycle pulse per second
// assumes CLK at the package rate
`timescale 1ns/1ps
`default_nettype none
module glr_sec_tick #(
    parameter int CYCLES = glr_pkg::SEC_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    glr_tick_if.src t
);
    logic [25:0] cnt_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 26'h000_0000;
        end else if (cnt_q == 26'(CYCLES - 1)) begin
            cnt_q <= 26'h000_0000;
        end else begin
            cnt_q <= cnt_q + 26'h000_0001;
        end
    end
    assign t.tick = (cnt_q == 26'(CYCLES - 1));
endmodule
`default_nettype wire
